/* File: rtl/stage_ctrl_regs.svh */
// Register offsets, bit positions, reset values and counts of the stage controller
`ifndef STAGE_CTRL_REGS_SVH
`define STAGE_CTRL_REGS_SVH

// ==========================================
// Register offsets
`define ADDR_RUN_CTRL   4'h0
`define ADDR_IN_A_CFG   4'h1
`define ADDR_IN_B_CFG   4'h2
`define ADDR_CAP_LO     4'h3
`define ADDR_CAP_HI     4'h4
`define ADDR_ON_TIME0   4'h5
`define ADDR_ON_TIME1   4'h6
`define ADDR_FINE       4'h7
`define ADDR_STATUS     4'h8

// ==========================================
// Run control bit positions
`define RC_DIV_MSB      7
`define RC_DIV_LSB      6
`define RC_BFM          5
`define RC_AOC_B        4
`define RC_AOC_A        3
`define RC_FOLLOW       2
`define RC_FINISH       1
`define RC_RUN          0

// ==========================================
// Reset values
`define RST_RUN_CTRL    8'h00
`define RST_IN_CFG      8'h00
`define RST_CAP         12'h000
`define RST_ON_TIME     8'h00
`define RST_FINE        4'h0

// ==========================================
// Counts
`define FILTER_SAMPLES  4
`define CYCLE_TOP       12'hFFF
`define DIV1_MASK       6'h00
`define DIV4_MASK       6'h03
`define DIV16_MASK      6'h0F
`define DIV64_MASK      6'h3F

`endif

/* File: rtl/stage_ctrl_pkg.sv */
// Types shared by the stage controller and its input blocks
package stage_ctrl_pkg;

    // ==========================================
    // Input block configuration, laid out as the register byte
    typedef struct packed {
        logic       capture_enable;
        logic       input_source_sel;
        logic       event_polarity;
        logic       noise_filter_en;
        logic [3:0] fault_retrigger_mode;
    } in_cfg_s;

    // ==========================================
    // Fault and retrigger mode codes
    typedef enum logic [3:0] {
        MODE_OFF        = 4'h0,
        MODE_JUMP_WAIT  = 4'h1,
        MODE_EXEC_WAIT  = 4'h2,
        MODE_EXEC_WHILE = 4'h3,
        MODE_DEACT      = 4'h4,
        MODE_INSERT_DT  = 4'h5,
        MODE_JUMP_WAIT2 = 4'h6,
        MODE_HALT       = 4'h7,
        MODE_RETRIG     = 4'h8,
        MODE_RETRIG_FF  = 4'h9,
        MODE_RETRIG_OFF = 4'hE
    } mode_e;

    // ==========================================
    // Run state, Gray coded along idle, run, finish
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RUN    = 2'b01,
        ST_FINISH = 2'b11,
        ST_HALTED = 2'b10
    } run_state_e;

endpackage

/* File: rtl/fault_input_block.sv */
// One retrigger/fault input block: source select, noise filter, polarity, event
`timescale 1ns/1ps
`include "stage_ctrl_regs.svh"

module fault_input_block
    import stage_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rst,
    // Configuration
    input  wire in_cfg_s cfg,
    // Sources
    input  wire logic    ext_fault_pin,
    input  wire logic    cmp_out,
    // Results
    output logic         raw_active,
    output logic         level_active,
    output logic         event_pulse
);

    logic                            sel_in;
    logic [`FILTER_SAMPLES-2:0]      hist;
    logic [`FILTER_SAMPLES-2:0]      next_hist;
    logic                            lvl;
    logic                            next_lvl;
    logic                            lvl_d;

    // ==========================================
    // source and level
    always_comb begin
        sel_in     = cfg.input_source_sel ? cmp_out : ext_fault_pin;
        raw_active = (sel_in == cfg.event_polarity);
    end

    always_comb begin
        next_hist = {hist[`FILTER_SAMPLES-3:0], sel_in};
        next_lvl  = lvl;
        if (!cfg.noise_filter_en) begin
            next_lvl = sel_in;
        end else if (hist == {(`FILTER_SAMPLES-1){sel_in}}) begin
            next_lvl = sel_in;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hist  <= '0;
            lvl   <= 1'b0;
            lvl_d <= 1'b0;
        end else begin
            hist  <= next_hist;
            lvl   <= next_lvl;
            lvl_d <= lvl;
        end
    end

    // Edge in the chosen direction on the filtered level
    always_comb begin
        level_active = (lvl == cfg.event_polarity);
        event_pulse  = (lvl != lvl_d) && (lvl == cfg.event_polarity);
    end

endmodule

/* File: rtl/stage_ctrl_fault_capture.sv */
// Third power stage: run control, prescaler, flank modulation, fault inputs, capture
// ==========================================
// Notes on behaviour
// - prescaler divides by 1, 4, 16, 64
// - balanced bit adds modulation to on-time 0
// - async B fault acts on out_b1/out_b3
// - async A fault acts on out_a0/out_a2
// - follow_start starts with previous stage chain
// - finish bit completes cycle before halting
// - finish bit ignored while following
// - writing run bit starts the stage
// - run bit prevails over follow_start
// - two identical, independently configured input blocks
// - capture enable makes events capture
// - source select picks pin or comparator
// - polarity picks falling/low or rising/high
// - filter needs four equal samples
// - mode 0 ignores, 1-7 fault behaviours
// - modes 8, 9, 14 are retrigger kinds
// - event loads counter into capture
// - capture read through shared temp nibble
// - capture is read only, writes ignored
`timescale 1ns/1ps
`include "stage_ctrl_regs.svh"

module stage_ctrl_fault_capture
    import stage_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Other stages
    input  wire logic       prev_stage_run,
    input  wire logic       prev_stage_follow,
    input  wire logic       first_stage_run,
    // Fault and retrigger sources
    input  wire logic       ext_fault_pin,
    input  wire logic       cmp_out,
    // Stage outputs
    output logic            out_a0,
    output logic            out_a2,
    output logic            out_b1,
    output logic            out_b3
);

    // ==========================================
    // Declarations
    logic [7:0]  run_ctrl;
    logic [7:0]  next_run_ctrl;
    logic [7:0]  cfg_a;
    logic [7:0]  next_cfg_a;
    logic [7:0]  cfg_b;
    logic [7:0]  next_cfg_b;
    logic [7:0]  on_time0;
    logic [7:0]  next_on_time0;
    logic [7:0]  on_time1;
    logic [7:0]  next_on_time1;
    logic [3:0]  fine;
    logic [3:0]  next_fine;
    logic [3:0]  temp_hi;
    logic [3:0]  next_temp_hi;
    logic [7:0]  next_rdata;
    logic        ctrl_write;

    run_state_e  state;
    run_state_e  next_state;
    logic        start_req;
    logic        cycle_end;

    logic [5:0]  div_cnt;
    logic [5:0]  next_div_cnt;
    logic [5:0]  div_mask;
    logic        tick;
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic [3:0]  fine_acc;
    logic [3:0]  next_fine_acc;
    logic        stretch;
    logic        next_stretch;

    logic [11:0] cap;
    logic [11:0] next_cap;

    in_cfg_s     cfg_a_s;
    in_cfg_s     cfg_b_s;
    logic        raw_a;
    logic        raw_b;
    logic        lvl_a;
    logic        lvl_b;
    logic        evt_a;
    logic        evt_b;
    logic        fault_a;
    logic        fault_b;
    logic        kill_a;
    logic        kill_b;
    logic        halt_evt;
    logic        restart;
    logic        cut_a;
    logic        next_cut_a;
    logic        cut_b;
    logic        next_cut_b;

    logic [11:0] len_a;
    logic [11:0] len_b;
    logic        drive_a;
    logic        drive_b;
    logic        next_out_a;
    logic        next_out_b;

    // ==========================================
    // Input blocks
    assign cfg_a_s = in_cfg_s'(cfg_a);
    assign cfg_b_s = in_cfg_s'(cfg_b);

    fault_input_block u_block_a (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .cfg           (cfg_a_s),
        .ext_fault_pin (ext_fault_pin),
        .cmp_out       (cmp_out),
        .raw_active    (raw_a),
        .level_active  (lvl_a),
        .event_pulse   (evt_a)
    );

    fault_input_block u_block_b (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .cfg           (cfg_b_s),
        .ext_fault_pin (ext_fault_pin),
        .cmp_out       (cmp_out),
        .raw_active    (raw_b),
        .level_active  (lvl_b),
        .event_pulse   (evt_b)
    );

    // ==========================================
    // Mode decode; reserved codes fall to no action
    always_comb begin
        fault_a  = (cfg_a_s.fault_retrigger_mode >= MODE_JUMP_WAIT) &&
                   (cfg_a_s.fault_retrigger_mode <= MODE_HALT);
        fault_b  = (cfg_b_s.fault_retrigger_mode >= MODE_JUMP_WAIT) &&
                   (cfg_b_s.fault_retrigger_mode <= MODE_HALT);
        halt_evt = (evt_a && (cfg_a_s.fault_retrigger_mode == MODE_HALT)) ||
                   (evt_b && (cfg_b_s.fault_retrigger_mode == MODE_HALT));
        // plain edge retrigger restarts the counter
        restart  = (evt_a && (cfg_a_s.fault_retrigger_mode == MODE_RETRIG)) ||
                   (evt_b && (cfg_b_s.fault_retrigger_mode == MODE_RETRIG));
        // unsynchronised fault A when async bit set
        kill_a   = fault_a && (run_ctrl[`RC_AOC_A] ? raw_a : lvl_a);
        // unsynchronised fault B when async bit set
        kill_b   = fault_b && (run_ctrl[`RC_AOC_B] ? raw_b : lvl_b);
    end

    // Fixed-frequency retrigger ends on-time of output B only but keeps period
    always_comb begin
        next_cut_a = cut_a;
        next_cut_b = cut_b;
        if (cycle_end || (state == ST_IDLE)) begin
            next_cut_a = 1'b0;
            next_cut_b = 1'b0;
        end
        if ((evt_a && (cfg_a_s.fault_retrigger_mode == MODE_RETRIG_FF)) ||
            (evt_b && (cfg_b_s.fault_retrigger_mode == MODE_RETRIG_FF))) begin
            next_cut_b = 1'b1;
        end
        if ((evt_a && (cfg_a_s.fault_retrigger_mode == MODE_RETRIG_OFF)) ||
            (evt_b && (cfg_b_s.fault_retrigger_mode == MODE_RETRIG_OFF))) begin
            next_cut_a = 1'b1;
            next_cut_b = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cut_a <= 1'b0;
            cut_b <= 1'b0;
        end else begin
            cut_a <= next_cut_a;
            cut_b <= next_cut_b;
        end
    end

    // ==========================================
    // Run state
    always_comb begin
        start_req = run_ctrl[`RC_RUN] ||
                    (run_ctrl[`RC_FOLLOW] &&
                     (prev_stage_run || (prev_stage_follow && first_stage_run)));
        ctrl_write = wr && (addr == `ADDR_RUN_CTRL);
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_req) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (halt_evt) begin
                    next_state = ST_HALTED;
                end else if (!start_req) begin
                    // finish the cycle only when asked
                    if (run_ctrl[`RC_FINISH] && !run_ctrl[`RC_FOLLOW]) begin
                        next_state = ST_FINISH;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_FINISH: begin
                if (halt_evt) begin
                    next_state = ST_HALTED;
                end else if (start_req) begin
                    next_state = ST_RUN;
                end else if (cycle_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HALTED: begin
                // Waits for software to touch the run control byte
                if (ctrl_write) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // Prescaler and waveform counter
    always_comb begin
        // divide by 1, 4, 16 or 64
        case (run_ctrl[`RC_DIV_MSB:`RC_DIV_LSB])
            2'b00:   div_mask = `DIV1_MASK;
            2'b01:   div_mask = `DIV4_MASK;
            2'b10:   div_mask = `DIV16_MASK;
            default: div_mask = `DIV64_MASK;
        endcase
        tick      = ((div_cnt & div_mask) == div_mask);
        cycle_end = tick && (cnt == `CYCLE_TOP);
        next_div_cnt = 6'h00;
        next_cnt     = 12'h000;
        if ((state == ST_RUN) || (state == ST_FINISH)) begin
            next_div_cnt = tick ? 6'h00 : div_cnt + 6'h01;
            next_cnt     = tick ? cnt + 12'h001 : cnt;
            if (restart) begin
                next_div_cnt = 6'h00;
                next_cnt     = 12'h000;
            end
        end else if (state == ST_HALTED) begin
            // Halt freezes the prescaler and counter where they stood
            next_div_cnt = div_cnt;
            next_cnt     = cnt;
        end
    end

    // Flank width modulation: spread the fine value over 16 cycles
    always_comb begin
        next_fine_acc = fine_acc;
        next_stretch  = stretch;
        if (state == ST_IDLE) begin
            next_fine_acc = 4'h0;
            next_stretch  = 1'b0;
        end else if (cycle_end) begin
            {next_stretch, next_fine_acc} = {1'b0, fine_acc} + {1'b0, fine};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt  <= 6'h00;
            cnt      <= 12'h000;
            fine_acc <= 4'h0;
            stretch  <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            cnt      <= next_cnt;
            fine_acc <= next_fine_acc;
            stretch  <= next_stretch;
        end
    end

    // ==========================================
    // Output waveform; state bit 0 marks run or finish, so a halt drives nothing
    always_comb begin
        // on-time 1 always modulated, on-time 0 only balanced
        len_a = {on_time0, 4'h0} + {11'h000, stretch && run_ctrl[`RC_BFM]};
        len_b = {on_time1, 4'h0} + {11'h000, stretch};
        drive_a = state[0] && (cnt < len_a);
        drive_b = state[0] && ((`CYCLE_TOP - cnt) < len_b);
        next_out_a = drive_a && !cut_a && !kill_a;
        next_out_b = drive_b && !cut_b && !kill_b;
    end

    // Async path skips the filter so a fault lands on the next edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_a0 <= 1'b0;
            out_a2 <= 1'b0;
            out_b1 <= 1'b0;
            out_b3 <= 1'b0;
        end else begin
            out_a0 <= next_out_a;
            out_a2 <= next_out_a;
            out_b1 <= next_out_b;
            out_b3 <= next_out_b;
        end
    end

    // ==========================================
    // Capture; block A wins when both fire together
    always_comb begin
        next_cap = cap;
        if (evt_a && cfg_a_s.capture_enable) begin
            next_cap = cnt;
        end else if (evt_b && cfg_b_s.capture_enable) begin
            next_cap = cnt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cap <= `RST_CAP;
        end else begin
            cap <= next_cap;
        end
    end

    // ==========================================
    // Register writes; capture offsets take no write
    always_comb begin
        next_run_ctrl = run_ctrl;
        next_cfg_a    = cfg_a;
        next_cfg_b    = cfg_b;
        next_on_time0 = on_time0;
        next_on_time1 = on_time1;
        next_fine     = fine;
        if (wr) begin
            case (addr)
                `ADDR_RUN_CTRL: next_run_ctrl = wdata;
                `ADDR_IN_A_CFG: next_cfg_a    = wdata;
                `ADDR_IN_B_CFG: next_cfg_b    = wdata;
                `ADDR_ON_TIME0: next_on_time0 = wdata;
                `ADDR_ON_TIME1: next_on_time1 = wdata;
                `ADDR_FINE:     next_fine     = wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_ctrl <= `RST_RUN_CTRL;
            cfg_a    <= `RST_IN_CFG;
            cfg_b    <= `RST_IN_CFG;
            on_time0 <= `RST_ON_TIME;
            on_time1 <= `RST_ON_TIME;
            fine     <= `RST_FINE;
        end else begin
            run_ctrl <= next_run_ctrl;
            cfg_a    <= next_cfg_a;
            cfg_b    <= next_cfg_b;
            on_time0 <= next_on_time0;
            on_time1 <= next_on_time1;
            fine     <= next_fine;
        end
    end

    // ==========================================
    // Register reads, data one cycle after the strobe
    always_comb begin
        next_rdata   = 8'h00;
        next_temp_hi = temp_hi;
        if (rd) begin
            case (addr)
                `ADDR_RUN_CTRL: next_rdata = run_ctrl;
                `ADDR_IN_A_CFG: next_rdata = cfg_a;
                `ADDR_IN_B_CFG: next_rdata = cfg_b;
                `ADDR_CAP_LO: begin
                    next_rdata   = cap[7:0];
                    next_temp_hi = cap[11:8];
                end
                `ADDR_CAP_HI:   next_rdata = {4'h0, temp_hi};
                `ADDR_ON_TIME0: next_rdata = on_time0;
                `ADDR_ON_TIME1: next_rdata = on_time1;
                `ADDR_FINE:     next_rdata = {4'h0, fine};
                `ADDR_STATUS:   next_rdata = {4'h0, state == ST_HALTED,
                                              state != ST_IDLE, lvl_b, lvl_a};
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata   <= 8'h00;
            temp_hi <= 4'h0;
        end else begin
            rdata   <= next_rdata;
            temp_hi <= next_temp_hi;
        end
    end

endmodule

/* File: sim/stage_ctrl_fault_capture_asserts.sv */
// Port-level assertions for the third stage controller
`timescale 1ns/1ps
`include "stage_ctrl_regs.svh"
module stage_ctrl_fault_capture_asserts (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Other stages and fault sources
    input wire logic       prev_stage_run,
    input wire logic       prev_stage_follow,
    input wire logic       first_stage_run,
    input wire logic       ext_fault_pin,
    input wire logic       cmp_out,
    // Stage outputs
    input wire logic       out_a0,
    input wire logic       out_a2,
    input wire logic       out_b1,
    input wire logic       out_b3
);
    // ==========================================
    // Shadow registers
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] ctrl_s, cfg_a, cfg_b;
    logic       hit_a, hit_b;
    // Mirror of software writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_s <= 8'h00;
            cfg_a  <= 8'h00;
            cfg_b  <= 8'h00;
        end else if (wr) begin
            if (addr == `ADDR_RUN_CTRL) ctrl_s <= wdata;
            if (addr == `ADDR_IN_A_CFG) cfg_a <= wdata;
            if (addr == `ADDR_IN_B_CFG) cfg_b <= wdata;
        end
    end
    // Direct fault: async bit, mode 1-7, raw input active
    assign hit_a = ctrl_s[`RC_AOC_A] && cfg_a[3:0] != 4'h0 && !cfg_a[3] && ((cfg_a[6] ? cmp_out : ext_fault_pin) == cfg_a[5]);
    assign hit_b = ctrl_s[`RC_AOC_B] && cfg_b[3:0] != 4'h0 && !cfg_b[3] && ((cfg_b[6] ? cmp_out : ext_fault_pin) == cfg_b[5]);
    a_rdata_quiet : assert property (!rd |=> rdata == 8'h00)
        else $error("rdata not idle");
    a_cap_hi_nibble : assert property (rd && addr == `ADDR_CAP_HI |=> rdata[7:4] == 4'h0)
        else $error("cap high bits");
    a_ctrl_readback : assert property (rd && addr == `ADDR_RUN_CTRL |=> rdata == $past(ctrl_s))
        else $error("ctrl readback");
    a_cfga_readback : assert property (rd && addr == `ADDR_IN_A_CFG |=> rdata == $past(cfg_a))
        else $error("cfg A readback");
    a_cfgb_readback : assert property (rd && addr == `ADDR_IN_B_CFG |=> rdata == $past(cfg_b))
        else $error("cfg B readback");
    a_pair_a_same : assert property (out_a0 == out_a2)
        else $error("A pair split");
    a_pair_b_same : assert property (out_b1 == out_b3)
        else $error("B pair split");
    a_async_a_off : assert property (hit_a |=> !out_a0 && !out_a2)
        else $error("A not cut");
    a_async_b_off : assert property (hit_b |=> !out_b1 && !out_b3)
        else $error("B not cut");
    a_stop_quick : assert property (wr && addr == `ADDR_RUN_CTRL && wdata == 8'h00 |-> ##3 !out_a0 && !out_b1)
        else $error("still driving");
    // Main scenarios reached
    c_cap_read : cover property (rd && addr == `ADDR_CAP_HI);
    c_hit_a    : cover property (hit_a);
    c_a_rise   : cover property ($rose(out_a0));
endmodule

/* File: sim/stage_far_side.sv */
// Far-side model: fault pin and comparator drivers, counts output A pulses
`timescale 1ns/1ps
module stage_far_side (
    // Clock
    input  wire logic sys_clk,
    // Levels asked for by the bench
    input  wire logic want_pin,
    input  wire logic want_cmp,
    // Stage side
    input  wire logic out_a0,
    output logic      ext_fault_pin = 1'b1,
    output logic      cmp_out = 1'b0,
    output int        a_edges = 0
);
    // ==========================================
    // Board signals
    logic last_a = 1'b0;
    // Lines move just after an edge
    always @(posedge sys_clk) begin
        ext_fault_pin <= want_pin;
        cmp_out       <= want_cmp;
        last_a        <= out_a0;
        if (out_a0 === 1'b1 && last_a === 1'b0) a_edges <= a_edges + 1;
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the third stage controller
`timescale 1ns/1ps
`include "stage_ctrl_regs.svh"
module testbench;
    // ==========================================
    // Stimulus and checks
    logic       sys_clk = 0, rst = 1, wr = 0, rd = 0, want_pin = 1, want_cmp = 0;
    logic       prev_stage_run = 0, prev_stage_follow = 0, first_stage_run = 0;
    logic       ext_fault_pin, cmp_out, out_a0, out_a2, out_b1, out_b3;
    logic [3:0] addr = 4'h0;
    logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE};
    logic [7:0] wdata = 8'h00, rdata, v;
    logic [11:0] c0, c1;
    int         err_total = 0, samples_checked = 0, n, a_edges;
    stage_ctrl_fault_capture dut (.*);
    stage_far_side far (.*);
    // 125 MHz clock
    initial forever #4 sys_clk = ~sys_clk;
    // Hang guard
    initial begin
        #500000;
        err_total++;
        test_done();
    end
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    // Read data sampled mid-cycle after the strobe
    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    task automatic rd_cap(output logic [11:0] c);
        logic [7:0] lo, hi;
        rreg(`ADDR_CAP_LO, lo);
        rreg(`ADDR_CAP_HI, hi);
        chk(hi[7:4], 0);
        c = {hi[3:0], lo};
    endtask
    // Bounded wait on output A; n counts cycles
    task automatic wait_a(input logic lvl);
        n = 0;
        while (out_a0 !== lvl && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        // reset values, writes to capture refused
        for (int a = 0; a < 5; a++) begin
            rreg(a[3:0], v);
            chk(v, 0);
        end
        wreg(`ADDR_CAP_LO, 8'hFF);
        wreg(`ADDR_CAP_HI, 8'hFF);
        rreg(`ADDR_CAP_LO, v);
        chk(v, 0);
        rreg(4'hF, v);
        chk(v, 0);
        foreach (modes[i]) begin
            wreg(`ADDR_IN_A_CFG, {4'h0, modes[i]});
            wreg(`ADDR_IN_B_CFG, {4'h1, modes[i]});
            rreg(`ADDR_IN_A_CFG, v);
            chk(v, {4'h0, modes[i]});
            rreg(`ADDR_IN_B_CFG, v);
            chk(v, {4'h1, modes[i]});
        end
        wreg(`ADDR_IN_A_CFG, 8'h00);
        wreg(`ADDR_IN_B_CFG, 8'h00);
        wreg(`ADDR_ON_TIME0, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wreg(`ADDR_RUN_CTRL, {c[1:0], 6'h01});
            wait_a(1'b1);
            wait_a(1'b0);
            chk(12'(n >= 15 << 2 * c && n <= 17 << 2 * c), 1);
            wreg(`ADDR_RUN_CTRL, 8'h00);
        end
        wreg(`ADDR_ON_TIME0, 8'h80);
        wreg(`ADDR_RUN_CTRL, 8'h03);
        cyc(20);
        chk(out_a0, 1);
        wreg(`ADDR_RUN_CTRL, 8'h02);
        cyc(4);
        chk(out_a0, 1);
        wreg(`ADDR_RUN_CTRL, 8'h01);
        wreg(`ADDR_RUN_CTRL, 8'h00);
        cyc(3);
        chk(out_a0, 0);
        wreg(`ADDR_RUN_CTRL, 8'h07);
        cyc(20);
        wreg(`ADDR_RUN_CTRL, 8'h06);
        cyc(3);
        chk(out_a0, 0);
        @(posedge sys_clk);
        prev_stage_run <= 1'b1;
        cyc(5);
        chk(out_a0, 1);
        @(posedge sys_clk);
        prev_stage_run    <= 1'b0;
        prev_stage_follow <= 1'b1;
        first_stage_run   <= 1'b1;
        cyc(5);
        chk(out_a0, 1);
        @(posedge sys_clk);
        first_stage_run <= 1'b0;
        cyc(5);
        chk(out_a0, 0);
        wreg(`ADDR_RUN_CTRL, 8'h05);
        cyc(5);
        chk(out_a0, 1);
        // direct fault action on both pairs
        wreg(`ADDR_IN_A_CFG, 8'h04);
        wreg(`ADDR_IN_B_CFG, 8'h64);
        wreg(`ADDR_RUN_CTRL, 8'h19);
        wreg(`ADDR_ON_TIME1, 8'hFF);
        cyc(5);
        chk(out_a0, 1);
        @(posedge sys_clk);
        want_pin <= 1'b0;
        cyc(3);
        chk({out_a0, out_a2}, 0);
        @(posedge sys_clk);
        want_pin <= 1'b1;
        cyc(6);
        chk(out_a0, 1);
        chk(out_b1, 1);
        @(posedge sys_clk);
        want_cmp <= 1'b1;
        cyc(3);
        chk({out_b1, out_b3}, 0);
        wreg(`ADDR_IN_B_CFG, 8'h00);
        want_cmp <= 1'b0;
        // falling pin event captures the counter
        wreg(`ADDR_IN_A_CFG, 8'h84);
        wreg(`ADDR_RUN_CTRL, 8'h00);
        wreg(`ADDR_RUN_CTRL, 8'h01);
        cyc(100);
        @(posedge sys_clk);
        want_pin <= 1'b0;
        cyc(8);
        rd_cap(c0);
        chk(12'(c0 > 12'd96 && c0 < 12'd112), 1);
        wreg(`ADDR_IN_A_CFG, 8'h04);
        @(posedge sys_clk);
        want_pin <= 1'b1;
        cyc(6);
        @(posedge sys_clk);
        want_pin <= 1'b0;
        cyc(8);
        rd_cap(c1);
        chk(c1, c0);
        wreg(`ADDR_IN_B_CFG, 8'hF4);
        @(posedge sys_clk);
        want_cmp <= 1'b1;
        @(posedge sys_clk);
        @(posedge sys_clk);
        want_cmp <= 1'b0;
        cyc(10);
        rd_cap(c1);
        chk(c1, c0);
        @(posedge sys_clk);
        want_cmp <= 1'b1;
        cyc(12);
        rd_cap(c1);
        chk(12'(c1 > c0), 1);
        chk(12'(a_edges != 0), 1);
        test_done();
    end
endmodule
bind stage_ctrl_fault_capture stage_ctrl_fault_capture_asserts chk_u (.*);
